// >>> hw/ir_receiver.sv
// Functional notes
// - Five frame formats: guide/no guide, pulse-position or Manchester.
// - Reference clock from eight sources: 1..128 cycles or subclock.
// - Valid bits shift in; each full byte moves to data, sets flag.
// - Receive-end flag set on the format's end-of-frame condition.
// - One interrupt when any flag and its enable are both set.
// - Hold-mode reception needs subclock; interrupt then releases hold.
// - Shift direction follows extension register bit 7.
// - Shift register clears on stop, guide, first edge, byte move.
// - 3-bit bit counter counts bits, clears like the shift register.
// - Suspend flag parks the receiver after a frame until cleared.
// - Guide divisor select unused in formats C and D.
// - Prescaler uses guide select in guide, data select for data.
// - Formats A to C: divisors 4, 8, 16, 32 reference clocks.
// - Formats D, E: divisors 2, 4, 8, 16 reference clocks.
// - Guide width register unused in formats C and D.
// - Zero width sets data 0 window, one width data 1; D, E: half-bit and full-bit windows.
// - Each limit is five bits: nibble plus extension bit.
// - 5-bit width counter advances on each prescaler count clock.
// - Filter needs four equal samples before accepting a level.
// - Rejection width varies by one reference clock either way.
// - Format codes 0..4 are A..E; other codes are prohibited.
// - Run bit low stops the receiver; high starts it.
// - Polarity bit high inverts the sampled input.
// - Flags set by hardware stay until software writes them clear.
`include "ir_rx_params.svh"

module ir_receiver (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire ir_rx_pkg::av_req_t av_req_i,
    output ir_rx_pkg::av_rsp_t     av_rsp_o,
    input  wire logic              ir_input_pin_i,
    input  wire logic              subclock_i,
    input  wire logic              hold_mode_i,
    output logic                   irq_o,
    output logic                   hold_release_o
);
    import ir_rx_pkg::*;

    ir_state_t   r_reg;
    ir_state_t   r_next;
    logic [1:0]  rst_sync_reg;
    logic        rst_q;
    logic        req;
    logic        wr_go;
    logic [15:0] idx;
    logic        run;
    logic [2:0]  fmt;
    logic [2:0]  refsel;
    logic        has_guide;
    logic        manch;
    logic        in_guide;
    logic [1:0]  psel;
    logic [6:0]  div_last;
    logic [4:0]  pre_last;
    logic        tick;
    logic        cc;
    logic        pin_lvl;
    logic [3:0]  nsamp;
    logic        edge_det;
    logic        wc_full;
    logic [4:0]  g_hi;
    logic [4:0]  g_lo;
    logic [4:0]  z_hi;
    logic [4:0]  z_lo;
    logic [4:0]  o_hi;
    logic [4:0]  o_lo;
    logic        bitv;
    logic        bitval;

    function automatic logic inr(input logic [4:0] v,
                                 input logic [4:0] lo,
                                 input logic [4:0] hi);
        inr = (v >= lo) && (v <= hi);
    endfunction

    // ==================================================================
    // Reset release
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_q = rst_sync_reg[1];

    // ==================================================================
    // Decode of configuration
    assign req      = av_req_i.read | av_req_i.write;
    assign wr_go    = av_req_i.write & r_reg.ack;
    assign idx      = av_req_i.address[17:2];
    assign run      = r_reg.ctrl[`IRRX_RUN_BIT];
    assign fmt      = r_reg.ctrl[6:4];
    assign refsel   = r_reg.ctrl[2:0];
    assign has_guide = (fmt == FMT_A) || (fmt == FMT_B) || (fmt == FMT_E);
    assign manch    = (fmt == FMT_D) || (fmt == FMT_E);
    assign in_guide = (r_reg.st == ST_WAIT) && has_guide;
    // guide or data select; C and D never use the guide select
    assign psel     = in_guide ? r_reg.ctpr[4:3] : r_reg.ctpr[2:1];
    assign pre_last = 5'(((fmt <= FMT_C) ? `IRRX_PRE_BASE_L
                                          : `IRRX_PRE_BASE_S) << psel) - 5'h01;
    assign div_last = 7'((`IRRX_REF_BASE << refsel) - 8'h01);
    // five-bit limits; data windows; guide unused in C/D
    assign g_hi = {r_reg.ext[1], r_reg.gw[7:4]};
    assign g_lo = {r_reg.ext[0], r_reg.gw[3:0]};
    assign z_hi = {r_reg.ext[3], r_reg.zw[7:4]};
    assign z_lo = {r_reg.ext[2], r_reg.zw[3:0]};
    assign o_hi = {r_reg.ext[5], r_reg.ow[7:4]};
    assign o_lo = {r_reg.ext[4], r_reg.ow[3:0]};

    // ==================================================================
    // Reference clock and filter
    // source select; cycle clock ticks stop in hold mode
    assign tick = run && ((refsel == `IRRX_REF_SUB)
                          ? (r_reg.sub_s[1] & ~r_reg.sub_s[2])
                          : (!hold_mode_i && ((refsel == `IRRX_REF_ONE) ||
                                              (r_reg.div == div_last))));
    assign pin_lvl  = r_reg.pin_s[1] ^ r_reg.ctrl[`IRRX_INV_BIT];
    assign nsamp    = {r_reg.samp[2:0], pin_lvl};
    // four equal samples, so width is 4 ticks give or take one
    assign edge_det = tick && ((&nsamp) || !(|nsamp))
                      && (nsamp[0] != r_reg.filt);
    assign cc       = tick && (r_reg.pre == pre_last);
    assign wc_full  = (r_reg.wc == `IRRX_WC_MAX);

    // ==================================================================
    // Interrupt
    // four sources gated by their enables
    assign irq_o = |(r_reg.irqc & `IRRX_FLAG_MASK &
                     {r_reg.irqc[6:0], 1'b0});
    // wake only when running from the subclock
    assign hold_release_o = irq_o && (refsel == `IRRX_REF_SUB);

    assign av_rsp_o.readdata    = {24'h000000, r_reg.rdata};
    assign av_rsp_o.waitrequest = req & ~r_reg.ack;

    // ==================================================================
    // Next state
    always_comb begin
        r_next = r_reg;
        bitv   = 1'b0;
        bitval = 1'b0;
        r_next.ack     = req & ~r_reg.ack;
        r_next.pin_s   = {r_reg.pin_s[0], ir_input_pin_i};
        r_next.sub_s   = {r_reg.sub_s[1:0], subclock_i};

        // Bus decode, read capture and writes share one case
        unique case (idx)
            `IRRX_CTRL_IDX: begin
                r_next.rdata = r_reg.ctrl;
                if (wr_go) begin
                    r_next.ctrl = av_req_i.writedata[7:0];
                end
            end
            `IRRX_IRQC_IDX: begin
                r_next.rdata = r_reg.irqc;
                // writing 0 clears a flag, writing 1 leaves it
                if (wr_go) begin
                    r_next.irqc = (av_req_i.writedata[7:0] &
                                   ~`IRRX_FLAG_MASK) |
                                  (av_req_i.writedata[7:0] & r_reg.irqc &
                                   `IRRX_FLAG_MASK);
                end
            end
            `IRRX_SHIFT_IDX: r_next.rdata = r_reg.shift;
            `IRRX_DATA_IDX:  r_next.rdata = r_reg.data;
            `IRRX_CTPR_IDX: begin
                r_next.rdata = {r_reg.ctpr, r_reg.bcnt};
                if (wr_go) begin
                    r_next.ctpr = av_req_i.writedata[7:3];
                end
            end
            `IRRX_GW_IDX: begin
                r_next.rdata = r_reg.gw;
                if (wr_go) begin
                    r_next.gw = av_req_i.writedata[7:0];
                end
            end
            `IRRX_ZW_IDX: begin
                r_next.rdata = r_reg.zw;
                if (wr_go) begin
                    r_next.zw = av_req_i.writedata[7:0];
                end
            end
            `IRRX_OW_IDX: begin
                r_next.rdata = r_reg.ow;
                if (wr_go) begin
                    r_next.ow = av_req_i.writedata[7:0];
                end
            end
            `IRRX_EXT_IDX: begin
                r_next.rdata = r_reg.ext;
                if (wr_go) begin
                    r_next.ext = av_req_i.writedata[7:0] & `IRRX_EXT_MASK;
                end
            end
            default: r_next.rdata = 8'h00;
        endcase
        if (!(req && !r_reg.ack)) begin
            r_next.rdata = r_reg.rdata;
        end
        if (av_req_i.address[1:0] != 2'h0) begin
            r_next.rdata = 8'h00;
        end

        // Timebase
        r_next.div = (!run || tick || r_reg.div == div_last) ?
                     7'h00 : r_reg.div + 7'h01;
        if (tick) begin
            r_next.samp = nsamp;
        end
        if (edge_det) begin
            r_next.filt = nsamp[0];
            r_next.pre  = 5'h00;
            r_next.wc   = 5'h00;
        end else if (tick) begin
            // prescaler wraps at the selected count
            r_next.pre = cc ? 5'h00 : r_reg.pre + 5'h01;
            // width counter saturates to mark silence
            if (cc && !wc_full) begin
                r_next.wc = r_reg.wc + 5'h01;
            end
        end

        unique case (r_reg.st)
            ST_STOP: begin
                r_next.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (edge_det) begin
                    if (!has_guide) begin
                        // first rising edge starts C and D
                        if (nsamp[0]) begin
                            r_next.shift = 8'h00;
                            r_next.bcnt  = 3'h0;
                            r_next.half  = 1'b0;
                            r_next.st    = ST_DATA;
                        end
                    end else if (!nsamp[0]) begin
                        r_next.gmark = (r_reg.wc >= g_hi);
                    end else if (r_reg.gmark && r_reg.wc >= g_lo) begin
                        // valid guide clears and starts data
                        r_next.irqc[7] = 1'b1;
                        r_next.shift   = 8'h00;
                        r_next.bcnt    = 3'h0;
                        r_next.half    = 1'b0;
                        r_next.gmark   = 1'b0;
                        r_next.st      = ST_DATA;
                    end else begin
                        r_next.gmark = 1'b0;
                    end
                end
            end
            ST_DATA: begin
                if (wc_full) begin
                    // silence ends the frame; suspend if asked
                    r_next.irqc[1] = 1'b1;
                    r_next.st = r_reg.ctpr[`IRRX_HOLD_BIT] ? ST_SUSP
                                                           : ST_WAIT;
                end else if (edge_det && manch) begin
                    if (inr(r_reg.wc, o_lo, o_hi)) begin
                        bitv   = 1'b1;
                        bitval = nsamp[0];
                        r_next.half = 1'b0;
                    end else if (inr(r_reg.wc, z_lo, z_hi)) begin
                        bitv   = r_reg.half;
                        bitval = nsamp[0];
                        r_next.half = ~r_reg.half;
                    end else begin
                        r_next.irqc[5] = 1'b1;
                        r_next.st      = ST_ERR;
                    end
                end else if (edge_det && nsamp[0]) begin
                    // space width picks 0, 1 or error
                    if (inr(r_reg.wc, z_lo, z_hi)) begin
                        bitv = 1'b1;
                    end else if (inr(r_reg.wc, o_lo, o_hi)) begin
                        bitv   = 1'b1;
                        bitval = 1'b1;
                    end else begin
                        r_next.irqc[5] = 1'b1;
                        r_next.st      = ST_ERR;
                    end
                end
            end
            ST_ERR: begin
                if (wc_full) begin
                    r_next.st = ST_WAIT;
                end
            end
            ST_SUSP: begin
                // resume once software drops the suspend flag
                if (!r_reg.ctpr[`IRRX_HOLD_BIT]) begin
                    r_next.st = ST_WAIT;
                end
            end
        endcase

        if (bitv) begin
            // direction: 1 enters at bit 0, 0 enters at bit 7
            r_next.shift = r_reg.ext[`IRRX_DIR_BIT] ?
                           {r_reg.shift[6:0], bitval} :
                           {bitval, r_reg.shift[7:1]};
            r_next.bcnt = r_reg.bcnt + 3'h1;
            if (r_reg.bcnt == 3'h7) begin
                // byte moves out and the shift register clears
                r_next.data    = r_next.shift;
                r_next.shift   = 8'h00;
                r_next.irqc[3] = 1'b1;
            end
        end

        if (!run) begin
            r_next.st    = ST_STOP;
            r_next.shift = 8'h00;
            r_next.bcnt  = 3'h0;
            r_next.samp  = 4'h0;
            r_next.filt  = 1'b0;
            r_next.pre   = 5'h00;
            r_next.wc    = 5'h00;
            r_next.gmark = 1'b0;
        end
    end

    // Data register has no defined start value in use; zero is harmless
    always_ff @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            r_reg <= '{ctpr: `IRRX_RST_CTPR, st: ST_STOP, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_q);

    a_bus_answer: assert property ( // bus
        req && av_rsp_o.waitrequest |=> !av_rsp_o.waitrequest)
        else $error("bus answer late");
    a_irq_gate: assert property (
        (r_reg.irqc[3] && r_reg.irqc[2]) |-> irq_o)
        else $error("irq not raised");
    a_byte_move: assert property (
        (bitv && r_reg.bcnt == 3'h7 && run)
        |=> r_reg.irqc[3] && r_reg.bcnt == 3'h0 && r_reg.shift == 8'h00)
        else $error("byte move wrong");
    a_stop_clear: assert property (
        !run |=> r_reg.shift == 8'h00 && r_reg.bcnt == 3'h0
                 && r_reg.st == ST_STOP)
        else $error("stop did not clear");
    a_bit_count: assert property (
        (bitv && run && r_reg.bcnt != 3'h7)
        |=> r_reg.bcnt == $past(r_reg.bcnt) + 3'h1)
        else $error("bit count wrong");
    a_filter_four: assert property (
        (run && r_reg.filt != $past(r_reg.filt))
        |-> r_reg.samp == {4{r_reg.filt}})
        else $error("filter took short pulse");
    a_flag_sticky: assert property (
        (r_reg.irqc[7] && !(wr_go && idx == `IRRX_IRQC_IDX))
        |=> r_reg.irqc[7])
        else $error("guide flag lost");
    a_no_guide_cd: assert property (
        (run && (fmt == FMT_C || fmt == FMT_D) && !r_reg.irqc[7]
         && !(wr_go && idx == `IRRX_CTRL_IDX)) |=> !r_reg.irqc[7])
        else $error("guide flag in format C or D");
    a_prescale_div: assert property (
        (run && fmt <= FMT_C && psel == 2'h0) |-> pre_last == 5'h03)
        else $error("prescale divisor wrong");
    a_suspend_hold: assert property (
        (r_reg.st == ST_SUSP && r_reg.ctpr[`IRRX_HOLD_BIT] && run)
        |=> r_reg.st == ST_SUSP)
        else $error("suspend left early");

endmodule

// >>> hw/ir_rx_params.svh
`ifndef IR_RX_PARAMS_SVH
`define IR_RX_PARAMS_SVH

// ======================================================================
// Register indexes (byte address is four times the index)
`define IRRX_CTRL_IDX   16'hfe27
`define IRRX_IRQC_IDX   16'hfe28
`define IRRX_SHIFT_IDX  16'hfe29
`define IRRX_DATA_IDX   16'hfe2a
`define IRRX_CTPR_IDX   16'hfe2b
`define IRRX_GW_IDX     16'hfe2c
`define IRRX_ZW_IDX     16'hfe2d
`define IRRX_OW_IDX     16'hfe2e
`define IRRX_EXT_IDX    16'hfe2f

// ======================================================================
// Reset values and field layout
`define IRRX_RST_BYTE   8'h00
`define IRRX_RST_CTPR   5'h00
`define IRRX_RUN_BIT    7
`define IRRX_INV_BIT    3
`define IRRX_DIR_BIT    7
`define IRRX_HOLD_BIT   0
`define IRRX_EXT_MASK   8'hbf
`define IRRX_FLAG_MASK  8'haa

// ======================================================================
// Timing
`define IRRX_REF_SUB    3'h6
`define IRRX_REF_ONE    3'h7
`define IRRX_REF_BASE   8'h04
`define IRRX_PRE_BASE_L 6'h04
`define IRRX_PRE_BASE_S 6'h02
`define IRRX_WC_MAX     5'h1f

`endif

// >>> hw/ir_rx_pkg.sv
package ir_rx_pkg;

    typedef enum logic [2:0] {
        FMT_A = 3'h0,
        FMT_B = 3'h1,
        FMT_C = 3'h2,
        FMT_D = 3'h3,
        FMT_E = 3'h4
    } frame_format_t;

    typedef enum logic [2:0] {
        ST_STOP,
        ST_WAIT,
        ST_DATA,
        ST_ERR,
        ST_SUSP
    } rx_state_t;

    typedef struct packed {
        logic [17:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } av_rsp_t;

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        logic [7:0]  ctrl;
        logic [7:0]  irqc;
        logic [7:0]  shift;
        logic [7:0]  data;
        logic [4:0]  ctpr;
        logic [2:0]  bcnt;
        logic [7:0]  gw;
        logic [7:0]  zw;
        logic [7:0]  ow;
        logic [7:0]  ext;
        logic [1:0]  pin_s;
        logic [2:0]  sub_s;
        logic [6:0]  div;
        logic [3:0]  samp;
        logic        filt;
        logic [4:0]  pre;
        logic [4:0]  wc;
        logic        half;
        logic        gmark;
        rx_state_t   st;
    } ir_state_t;

endpackage

// >>> testbench/ir_remote_model.sv
module ir_remote_model (
    input  wire logic clock_i,
    output logic      ir_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic inv = 1'b0;

    initial ir_o = 1'b0;

    // ==================================================================
    // Pin driver
    // polarity invert
    task automatic drive(input logic v, input int cyc);
        ir_o <= v ^ inv;
        repeat (cyc) @(posedge clock_i);
    endtask

    // ==================================================================
    // Frames
    // Low widths sit mid-window so one tick of filter skew is harmless
    task automatic send(input logic [15:0] bits, input int n, input int bad);
        drive(1'b1, 8);
        for (int i = 0; i < n; i++) begin
            drive(1'b0, (i == bad) ? 20 : (bits[i] ? 32 : 8));
            drive(1'b1, 8);
        end
        drive(1'b0, 200);
    endtask

    task automatic glitch();
        drive(1'b1, 2);
        drive(1'b0, 200);
    endtask
endmodule

// >>> testbench/ir_receiver_tb_top.sv
`include "ir_rx_params.svh"

module ir_receiver_tb_top import ir_rx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    av_req_t     bus_req = '0;
    av_rsp_t     bus_rsp;
    logic        ir_pin;
    logic        sub_clk = 1'b0;
    logic        hold_mode = 1'b0;
    logic        irq_o;
    logic        hold_release_o;
    logic [7:0]  rd;
    int          failures = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [15:0] regs [8] = '{`IRRX_CTRL_IDX, `IRRX_IRQC_IDX,
        `IRRX_SHIFT_IDX, `IRRX_CTPR_IDX, `IRRX_GW_IDX, `IRRX_ZW_IDX,
        `IRRX_OW_IDX, 16'hfe30};

    always #20 clock_i = ~clock_i;

    // Subclock rises every second cycle, slow enough to be sampled
    always @(posedge clock_i) begin
        sub_clk <= ~sub_clk;
    end

    ir_receiver u_dut (
        .clock_i        (clock_i),
        .rst_n_i        (rst_n_i),
        .av_req_i       (bus_req),
        .av_rsp_o       (bus_rsp),
        .ir_input_pin_i (ir_pin),
        .subclock_i     (sub_clk),
        .hold_mode_i    (hold_mode),
        .irq_o          (irq_o),
        .hold_release_o (hold_release_o)
    );

    ir_remote_model u_remote (
        .clock_i (clock_i),
        .ir_o    (ir_pin)
    );

    // ==================================================================
    // Helpers
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [15:0] idx, input logic wr,
                       input logic [7:0] wd);
        @(posedge clock_i);
        bus_req <= '{address: {idx, 2'b00}, read: !wr, write: wr,
                     writedata: {24'h0, wd}};
        do begin
            @(posedge clock_i);
        end while (bus_rsp.waitrequest !== 1'b0);
        rd = bus_rsp.readdata[7:0];
        bus_req <= '0;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [15:0] idx, input string what,
                          input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        check(what, rd, exp);
    endtask

    function automatic logic [7:0] model_sr(input logic [15:0] b,
        input int lo, input int n, input logic msb);
        logic [7:0] s;
        s = 8'h00;
        for (int i = lo; i < lo + n; i++) begin
            s = msb ? {s[6:0], b[i]} : {b[i], s[7:1]};
        end
        return s;
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run needs well under 10000 cycles
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            wrap_up();
        end
    end

    // ==================================================================
    // Tests
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        for (int i = 0; i < 8; i++) begin
            rd_chk(regs[i], "reset value", 8'h00);
        end
        $display("test reset done");

        bus(`IRRX_EXT_IDX, 1'b1, 8'hff);
        rd_chk(`IRRX_EXT_IDX, "extension", 8'hbf);
        bus(`IRRX_CTPR_IDX, 1'b1, 8'h07);
        rd_chk(`IRRX_CTPR_IDX, "count bits", 8'h00);
        bus(`IRRX_SHIFT_IDX, 1'b1, 8'hff);
        rd_chk(`IRRX_SHIFT_IDX, "shift write", 8'h00);
        bus(16'hfe30, 1'b1, 8'hff);
        rd_chk(16'hfe30, "unmapped", 8'h00);
        for (int f = 0; f < 5; f++) begin
            bus(`IRRX_CTRL_IDX, 1'b1, {1'b0, 3'(f), 4'h7});
            rd_chk(`IRRX_CTRL_IDX, "format", {1'b0, 3'(f), 4'h7});
        end
        $display("test access done");

        bus(`IRRX_EXT_IDX, 1'b1, 8'h00);
        bus(`IRRX_ZW_IDX, 1'b1, 8'h31);
        bus(`IRRX_OW_IDX, 1'b1, 8'h97);
        bus(`IRRX_CTPR_IDX, 1'b1, 8'h00);
        bus(`IRRX_IRQC_IDX, 1'b1, 8'h05);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'ha7);
        u_remote.send(16'h05a5, 11, -1);
        rd_chk(`IRRX_DATA_IDX, "data", model_sr(16'h05a5, 0, 8, 0));
        rd_chk(`IRRX_SHIFT_IDX, "tail", model_sr(16'h05a5, 8, 3, 0));
        bus(`IRRX_CTPR_IDX, 1'b0, 8'h00);
        check("bit count", {5'h0, rd[2:0]}, 8'h03);
        rd_chk(`IRRX_IRQC_IDX, "flags", 8'h0f);
        check("irq", {7'h0, irq_o}, 8'h01);
        check("hold release", {7'h0, hold_release_o}, 8'h00);
        bus(`IRRX_IRQC_IDX, 1'b1, 8'haa);
        rd_chk(`IRRX_IRQC_IDX, "flags kept", 8'h0a);
        check("irq masked", {7'h0, irq_o}, 8'h00);
        bus(`IRRX_IRQC_IDX, 1'b1, 8'h05);
        rd_chk(`IRRX_IRQC_IDX, "flags cleared", 8'h05);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'h27);
        rd_chk(`IRRX_SHIFT_IDX, "shift stop", 8'h00);
        rd_chk(`IRRX_CTPR_IDX, "count stop", 8'h00);
        $display("test lsb frame done");

        bus(`IRRX_EXT_IDX, 1'b1, 8'h80);
        bus(`IRRX_CTPR_IDX, 1'b1, 8'h08);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'ha7);
        u_remote.send(16'h03c6, 10, -1);
        rd_chk(`IRRX_DATA_IDX, "data", model_sr(16'h03c6, 0, 8, 1));
        rd_chk(`IRRX_SHIFT_IDX, "tail", model_sr(16'h03c6, 8, 2, 1));
        rd_chk(`IRRX_IRQC_IDX, "flags", 8'h0f);
        bus(`IRRX_IRQC_IDX, 1'b1, 8'h05);
        u_remote.send(16'h00ff, 8, -1);
        rd_chk(`IRRX_IRQC_IDX, "suspended", 8'h05);
        bus(`IRRX_CTPR_IDX, 1'b1, 8'h00);
        u_remote.send(16'h00ff, 8, -1);
        rd_chk(`IRRX_IRQC_IDX, "resumed", 8'h0f);
        rd_chk(`IRRX_DATA_IDX, "data", 8'hff);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'h27);
        $display("test msb suspend done");

        u_remote.inv = 1'b1;
        u_remote.drive(1'b0, 8);
        bus(`IRRX_EXT_IDX, 1'b1, 8'h00);
        bus(`IRRX_IRQC_IDX, 1'b1, 8'h10);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'haf);
        u_remote.send(16'h0001, 3, 2);
        rd_chk(`IRRX_SHIFT_IDX, "shift", model_sr(16'h0001, 0, 2, 0));
        bus(`IRRX_CTPR_IDX, 1'b0, 8'h00);
        check("bit count", {5'h0, rd[2:0]}, 8'h02);
        bus(`IRRX_IRQC_IDX, 1'b0, 8'h00);
        check("error flag", rd & 8'h30, 8'h30);
        check("irq error", {7'h0, irq_o}, 8'h01);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'h2f);
        u_remote.inv = 1'b0;
        u_remote.drive(1'b0, 8);
        $display("test invert error done");

        bus(`IRRX_IRQC_IDX, 1'b1, 8'h01);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'ha7);
        u_remote.glitch();
        rd_chk(`IRRX_IRQC_IDX, "glitch", 8'h01);
        rd_chk(`IRRX_CTPR_IDX, "glitch count", 8'h00);
        $display("test glitch done");

        bus(`IRRX_EXT_IDX, 1'b1, 8'h20);
        bus(`IRRX_ZW_IDX, 1'b1, 8'h43);
        bus(`IRRX_OW_IDX, 1'b1, 8'hff);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'hb7);
        u_remote.send(16'h0002, 3, -1);
        rd_chk(`IRRX_SHIFT_IDX, "manchester", 8'he0);
        rd_chk(`IRRX_IRQC_IDX, "manchester end", 8'h03);
        bus(`IRRX_CTPR_IDX, 1'b0, 8'h00);
        check("manchester count", {5'h0, rd[2:0]}, 8'h03);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'h37);
        $display("test manchester done");

        // Cycle clock held, so only subclock ticks can time the guide
        bus(`IRRX_IRQC_IDX, 1'b1, 8'h40);
        hold_mode <= 1'b1;
        bus(`IRRX_CTRL_IDX, 1'b1, 8'h86);
        u_remote.send(16'h0000, 2, -1);
        bus(`IRRX_IRQC_IDX, 1'b0, 8'h00);
        check("guide flag", rd & 8'hc0, 8'hc0);
        check("guide irq", {7'h0, irq_o}, 8'h01);
        check("hold wake", {7'h0, hold_release_o}, 8'h01);
        bus(`IRRX_CTRL_IDX, 1'b1, 8'h06);
        hold_mode <= 1'b0;
        $display("test subclock guide done");
        wrap_up();
    end
endmodule
